// ### verilog/hpm_device.sv
// Device end: host register port, memory control, shared buffer RAM and CPU register port
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module hpm_device (
  hpm_if.dev                                  link,
  input  wire logic                           i_clk,
  input  wire logic                           i_srst,
  input  wire logic [hpm_pkg::CPU_A_W-1:0]    i_cpu_addr,
  input  wire logic [hpm_pkg::DATA_W-1:0]     i_cpu_wdata,
  input  wire logic                           i_cpu_wr,
  input  wire logic                           i_cpu_rd,
  output logic [hpm_pkg::DATA_W-1:0]          o_cpu_rdata
);
  localparam int DW = hpm_pkg::DATA_W;
  localparam int AW = hpm_pkg::RADDR_W;

  logic [DW-1:0]              ram [hpm_pkg::RAM_D];
  logic [hpm_pkg::IDX_W-1:0]  index_r;
  logic                       byte_order_r;
  logic                       word_swap_r;
  logic                       lock_r;
  logic                       rd_req_r;
  logic                       wt_req_r;
  logic                       dir_r;
  logic [AW-1:0]              baddr_r;
  logic [DW-1:0]              dport_r;
  logic                       fetch_pend_r;
  logic [DW-1:0]              hp_rdata_r;
  logic                       hp_rvalid_r;
  logic [DW-1:0]              cpu_rdata_r;

  // Host-side decode; pin high addresses the index register
  wire hw_idx   = link.hp_wr && link.hp_rs;
  wire hw_reg   = link.hp_wr && !link.hp_rs;
  wire hr_reg   = link.hp_rd && !link.hp_rs;
  wire sel_ctrl = (index_r == hpm_pkg::IDX_CTRL);
  wire sel_mc   = (index_r == hpm_pkg::IDX_MEMCTL);
  wire sel_ba   = (index_r == hpm_pkg::IDX_BADDR);
  wire sel_dp   = (index_r == hpm_pkg::IDX_DPORT);

  // Register bytes follow the byte order bit; data port may use word swap instead
  wire [DW-1:0] reg_wdata = byte_order_r ? hpm_pkg::byte_rev(link.hp_wdata) : link.hp_wdata;
  wire [DW-1:0] dp_wdata  = word_swap_r ? hpm_pkg::word_swap(link.hp_wdata) : reg_wdata;

  wire mode_cread  = lock_r && rd_req_r;
  wire mode_cwrite = lock_r && wt_req_r;

  // Memory control view; reserved bits are never stored, so they read zero
  wire [DW-1:0] mc_view = {24'h000000, lock_r, 1'b0, wt_req_r, 1'b0, rd_req_r, 2'b00, dir_r};
  wire [DW-1:0] ctrl_view = {29'h00000000, word_swap_r, 1'b0, byte_order_r};
  wire [DW-1:0] mc_w = reg_wdata & hpm_pkg::MC_WMASK;

  // FIFO between data port writes and the RAM
  logic                       fifo_in_valid;
  logic                       fifo_in_ready;
  logic [hpm_pkg::FIFO_W-1:0] fifo_in_data;
  logic                       fifo_out_valid;
  logic [hpm_pkg::FIFO_W-1:0] fifo_out_data;

  wire cpu_ram   = (i_cpu_addr >= hpm_pkg::CPU_RAM);
  wire cpu_ram_a = cpu_ram && (i_cpu_wr || i_cpu_rd);
  // CPU RAM access owns the RAM port that cycle; drain and fetch simply wait
  wire drain     = fifo_out_valid && !cpu_ram_a;
  wire fetch_go  = fetch_pend_r && !fifo_out_valid && !cpu_ram_a;
  wire dp_host_w = hw_reg && sel_dp;
  wire dp_host_r = hr_reg && sel_dp;
  wire push_cw   = dp_host_w && mode_cwrite;
  wire push_once = wt_req_r && !lock_r && !fetch_pend_r;
  wire [AW-1:0] baddr_step = dir_r ? (baddr_r - hpm_pkg::ADDR_STEP) : (baddr_r + hpm_pkg::ADDR_STEP);

  assign fifo_in_valid = push_cw || push_once;
  assign fifo_in_data  = {baddr_r, (push_cw ? dp_wdata : dport_r)};
  // Back-pressure: host waits while a fetch or a single write is outstanding or the FIFO is full
  assign link.hp_ready = fifo_in_ready && !fetch_pend_r && !(wt_req_r && !lock_r);
  assign link.hp_rdata  = hp_rdata_r;
  assign link.hp_rvalid = hp_rvalid_r;
  assign o_cpu_rdata    = cpu_rdata_r;

  hpm_fifo #(
    .W (hpm_pkg::FIFO_W),
    .D (hpm_pkg::FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (!cpu_ram_a),
    .o_out_data  (fifo_out_data)
  );

  wire [AW-1:0]  drain_addr = fifo_out_data[hpm_pkg::FIFO_W-1:DW];
  wire [5:0]     cpu_widx   = i_cpu_addr[7:2];
  wire [DW-1:0]  fetch_word = ram[baddr_r[7:2]];

  always_ff @(posedge i_clk) begin
    if (cpu_ram && i_cpu_wr) begin
      ram[cpu_widx] <= i_cpu_wdata;
    end else if (drain) begin
      ram[drain_addr[7:2]] <= fifo_out_data[DW-1:0];
    end
  end

  // Index and order controls; CPU write wins a same-cycle collision
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      index_r      <= '0;
      byte_order_r <= 1'b0;
      word_swap_r  <= 1'b0;
    end else begin
      if (hw_idx) index_r <= reg_wdata[hpm_pkg::IDX_W-1:0];
      if (i_cpu_wr && i_cpu_addr == hpm_pkg::CPU_CTRL) begin
        byte_order_r <= i_cpu_wdata[hpm_pkg::CTRL_BO];
        word_swap_r  <= i_cpu_wdata[hpm_pkg::CTRL_WSWP];
      end else if (hw_reg && sel_ctrl) begin
        byte_order_r <= reg_wdata[hpm_pkg::CTRL_BO];
        word_swap_r  <= reg_wdata[hpm_pkg::CTRL_WSWP];
      end
    end
  end

  // Memory control: written only from the host side
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lock_r   <= 1'b0;
      rd_req_r <= 1'b0;
      wt_req_r <= 1'b0;
      dir_r    <= 1'b0;
    end else if (hw_reg && sel_mc) begin
      lock_r <= mc_w[hpm_pkg::MC_LOCK];
      dir_r  <= mc_w[hpm_pkg::MC_DIR];
      if (!(lock_r && mc_w[hpm_pkg::MC_LOCK])) begin
        rd_req_r <= mc_w[hpm_pkg::MC_RD];
        wt_req_r <= mc_w[hpm_pkg::MC_WT];
      end
    end else begin
      if (fetch_go && !lock_r) rd_req_r <= 1'b0;
      if (push_once && fifo_in_ready) wt_req_r <= 1'b0;
    end
  end

  // Data port, buffer address and pending fetch
  wire mc_rd_set = hw_reg && sel_mc && mc_w[hpm_pkg::MC_RD] && !(lock_r && mc_w[hpm_pkg::MC_LOCK]);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dport_r      <= hpm_pkg::RST_DATA;
      baddr_r      <= hpm_pkg::RST_ADDR;
      fetch_pend_r <= 1'b0;
    end else begin
      if (fetch_go) dport_r <= fetch_word;
      // A request landing in the fetch cycle must not be lost
      if (mc_rd_set || (dp_host_r && mode_cread)) begin
        fetch_pend_r <= 1'b1;
      end else if (fetch_go) begin
        fetch_pend_r <= 1'b0;
      end
      if (dp_host_w && !mode_cwrite) dport_r <= dp_wdata;
      if ((fetch_go && lock_r) || (push_cw && fifo_in_ready)) begin
        baddr_r <= baddr_step;
      end else if (hw_reg && sel_ba) begin
        baddr_r <= reg_wdata[AW-1:0];
      end
    end
  end

  // Host read path, answered one cycle later
  wire [DW-1:0] hp_raw = sel_ctrl ? ctrl_view :
                         sel_mc   ? mc_view :
                         sel_ba   ? {24'h000000, baddr_r} :
                         sel_dp   ? dport_r : hpm_pkg::RST_DATA;
  wire [DW-1:0] hp_idx_v = {26'h0000000, index_r};
  wire [DW-1:0] hp_ord   = byte_order_r ? hpm_pkg::byte_rev(hp_raw) : hp_raw;
  wire [DW-1:0] hp_dpo   = word_swap_r ? hpm_pkg::word_swap(dport_r) : hp_ord;
  wire [DW-1:0] hp_idxo  = byte_order_r ? hpm_pkg::byte_rev(hp_idx_v) : hp_idx_v;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hp_rdata_r  <= hpm_pkg::RST_DATA;
      hp_rvalid_r <= 1'b0;
    end else begin
      hp_rvalid_r <= link.hp_rd;
      if (link.hp_rd) hp_rdata_r <= link.hp_rs ? hp_idxo : (sel_dp ? hp_dpo : hp_ord);
    end
  end

  // CPU read path
  wire [DW-1:0] cpu_stat = {27'h0000000, fetch_pend_r, fifo_out_valid, !fifo_in_ready, mode_cwrite, mode_cread};
  wire [DW-1:0] cpu_raw;
  assign cpu_raw = (i_cpu_addr == hpm_pkg::CPU_MEMCTL) ? mc_view :
                   (i_cpu_addr == hpm_pkg::CPU_CTRL)   ? ctrl_view :
                   (i_cpu_addr == hpm_pkg::CPU_BADDR)  ? {24'h000000, baddr_r} :
                   (i_cpu_addr == hpm_pkg::CPU_STAT)   ? cpu_stat :
                   cpu_ram                             ? ram[cpu_widx] : hpm_pkg::RST_DATA;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cpu_rdata_r <= hpm_pkg::RST_DATA;
    end else if (i_cpu_rd) begin
      cpu_rdata_r <= cpu_raw;
    end
  end
endmodule

// ### verilog/hpm_pkg.sv
// Shared constants, field positions and byte-order helpers for the host port memory block
package hpm_pkg;
  localparam int DATA_W   = 32;
  localparam int IDX_W    = 6;
  localparam int RADDR_W  = 8;
  localparam int RAM_D    = 64;
  localparam int FIFO_D   = 16;
  localparam int FIFO_W   = RADDR_W + DATA_W;
  localparam int CPU_A_W  = 9;

  // Host-side register indices, selected through the index register
  localparam logic [IDX_W-1:0] IDX_CTRL   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_MEMCTL = 6'h01;
  localparam logic [IDX_W-1:0] IDX_BADDR  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_DPORT  = 6'h03;

  // CPU-side byte addresses
  localparam logic [CPU_A_W-1:0] CPU_MEMCTL = 9'h000;
  localparam logic [CPU_A_W-1:0] CPU_CTRL   = 9'h004;
  localparam logic [CPU_A_W-1:0] CPU_BADDR  = 9'h008;
  localparam logic [CPU_A_W-1:0] CPU_STAT   = 9'h00C;
  localparam logic [CPU_A_W-1:0] CPU_RAM    = 9'h100;

  // Field positions
  localparam int CTRL_BO    = 0;
  localparam int CTRL_WSWP  = 2;
  localparam int MC_LOCK    = 7;
  localparam int MC_RSV6    = 6;
  localparam int MC_WT      = 5;
  localparam int MC_RD      = 3;
  localparam int MC_DIR     = 0;
  localparam logic [DATA_W-1:0] MC_WMASK = 32'h000000A9;

  // Reset values and buffer address step
  localparam logic [DATA_W-1:0]  RST_DATA = 32'h00000000;
  localparam logic [RADDR_W-1:0] RST_ADDR = 8'h00;
  localparam logic [RADDR_W-1:0] ADDR_STEP = 8'h04;

  function automatic logic [DATA_W-1:0] byte_rev(input logic [DATA_W-1:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // Halves swapped, then bytes inside each half
  function automatic logic [DATA_W-1:0] word_swap(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] h;
    h = {d[15:0], d[31:16]};
    return {h[23:16], h[31:24], h[7:0], h[15:8]};
  endfunction
endpackage

// ### verilog/hpm_if.sv
// Parallel host port link between the external host and the device
`timescale 1ns/100ps
interface hpm_if;
  logic                         hp_rs;
  logic                         hp_wr;
  logic                         hp_rd;
  logic [hpm_pkg::DATA_W-1:0]   hp_wdata;
  logic [hpm_pkg::DATA_W-1:0]   hp_rdata;
  logic                         hp_rvalid;
  logic                         hp_ready;

  modport dev  (input hp_rs, hp_wr, hp_rd, hp_wdata, output hp_rdata, hp_rvalid, hp_ready);
  modport host (output hp_rs, hp_wr, hp_rd, hp_wdata, input hp_rdata, hp_rvalid, hp_ready);
endinterface

// ### verilog/hpm_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/100ps
module hpm_fifo #(
  parameter int W = 40,
  parameter int D = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  wire           push = i_in_valid && o_in_ready;
  wire           pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (cnt_r != (AW+1)'(D));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem[rp_r];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### verilog/hpm_host.sv
// Host end: turns user register requests into index-then-access sequences on the link
`timescale 1ns/100ps
module hpm_host (
  hpm_if.host                                 link,
  input  wire logic                           i_clk,
  input  wire logic                           i_srst,
  input  wire logic                           i_req,
  input  wire logic                           i_wr,
  input  wire logic [hpm_pkg::IDX_W-1:0]      i_index,
  input  wire logic [hpm_pkg::DATA_W-1:0]     i_wdata,
  output logic                                o_busy,
  output logic [hpm_pkg::DATA_W-1:0]          o_rdata,
  output logic                                o_rvalid
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IDX  = 2'b01,
    ST_ACC  = 2'b10,
    ST_WAIT = 2'b11
  } hpm_hstate_t;

  hpm_hstate_t                 st_r;
  logic                        wr_r;
  logic [hpm_pkg::IDX_W-1:0]   idx_r;
  logic [hpm_pkg::DATA_W-1:0]  wdata_r;
  logic                        rs_r;
  logic                        hwr_r;
  logic                        hrd_r;
  logic [hpm_pkg::DATA_W-1:0]  hwdata_r;
  logic [hpm_pkg::DATA_W-1:0]  rdata_r;
  logic                        rvalid_r;

  // Reserved bits forced to zero; read wins if both requests are asked for
  wire [hpm_pkg::DATA_W-1:0] mc_clean = i_wdata & hpm_pkg::MC_WMASK;
  wire both_req = mc_clean[hpm_pkg::MC_RD] && mc_clean[hpm_pkg::MC_WT];
  wire [hpm_pkg::DATA_W-1:0] mc_safe = both_req ? (mc_clean & ~(32'h1 << hpm_pkg::MC_WT)) : mc_clean;
  wire [hpm_pkg::DATA_W-1:0] w_in = (i_index == hpm_pkg::IDX_MEMCTL) ? mc_safe : i_wdata;

  assign link.hp_rs    = rs_r;
  assign link.hp_wr    = hwr_r;
  assign link.hp_rd    = hrd_r;
  assign link.hp_wdata = hwdata_r;
  assign o_busy        = (st_r != ST_IDLE);
  assign o_rdata       = rdata_r;
  assign o_rvalid      = rvalid_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r     <= ST_IDLE;
      wr_r     <= 1'b0;
      idx_r    <= '0;
      wdata_r  <= hpm_pkg::RST_DATA;
      rs_r     <= 1'b1;
      hwr_r    <= 1'b0;
      hrd_r    <= 1'b0;
      hwdata_r <= hpm_pkg::RST_DATA;
      rdata_r  <= hpm_pkg::RST_DATA;
      rvalid_r <= 1'b0;
    end else begin
      hwr_r    <= 1'b0;
      hrd_r    <= 1'b0;
      rvalid_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (i_req) begin
            wr_r    <= i_wr;
            idx_r   <= i_index;
            wdata_r <= w_in;
            st_r    <= ST_IDX;
          end
        end
        ST_IDX: begin
          rs_r     <= 1'b1;
          hwr_r    <= 1'b1;
          hwdata_r <= {26'h0000000, idx_r};
          st_r     <= ST_ACC;
        end
        ST_ACC: begin
          if (link.hp_ready && !hwr_r) begin
            rs_r     <= 1'b0;
            hwr_r    <= wr_r;
            hrd_r    <= !wr_r;
            hwdata_r <= wdata_r;
            st_r     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link.hp_rvalid) begin
            rdata_r  <= link.hp_rdata;
            rvalid_r <= 1'b1;
            st_r     <= ST_IDLE;
          end else if (wr_r) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### test/hpm_props.sv
// Link-side assertions for the host port between the host and device ends
`timescale 1ns/100ps
module hpm_props (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        hp_rs,
  input wire logic        hp_wr,
  input wire logic        hp_rd,
  input wire logic [31:0] hp_wdata,
  input wire logic [31:0] hp_rdata,
  input wire logic        hp_rvalid,
  input wire logic        hp_ready
);
  logic [5:0] idx_r;
  logic       lock_r;
  logic       dir_r;
  logic       hrd_r;
  logic       hwt_r;
  wire logic  mc_acc = !hp_rs && (idx_r == hpm_pkg::IDX_MEMCTL);
  wire logic  mc_wr  = hp_wr && mc_acc;
  wire logic  mc_rd  = hp_rd && mc_acc;

  // Shadow assumes big-endian link words; bench keeps the order bit clear around these accesses
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      idx_r  <= 6'h00;
      lock_r <= 1'b0;
      dir_r  <= 1'b0;
      hrd_r  <= 1'b0;
      hwt_r  <= 1'b0;
    end else begin
      if (hp_wr && hp_rs)
        idx_r <= hp_wdata[5:0];
      if (mc_wr) begin
        lock_r <= hp_wdata[7];
        dir_r  <= hp_wdata[0];
      end
      // Requests latch unless the lock is already held and kept held by this write
      if (mc_wr && !(lock_r && hp_wdata[7])) begin
        hrd_r <= hp_wdata[3];
        hwt_r <= hp_wdata[5];
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_rvalid_follows: assert property (hp_rd |=> hp_rvalid)
    else $error("read strobe not answered next cycle");
  a_rvalid_cause: assert property (hp_rvalid |-> $past(hp_rd))
    else $error("read valid without a read strobe");
  a_strobes_apart: assert property (!(hp_rd && hp_wr))
    else $error("read and write strobes together");
  a_access_ready: assert property (!hp_rs && (hp_rd || hp_wr) |-> hp_ready)
    else $error("indexed access while not ready");
  a_rsv_read_zero: assert property (mc_rd |=> hp_rdata[31:8] == 24'h000000 && !hp_rdata[6])
    else $error("reserved control bits read nonzero");
  a_rsv_write_zero: assert property (mc_wr |-> hp_wdata[31:8] == 24'h000000 && !hp_wdata[6])
    else $error("reserved control bits written nonzero");
  a_req_not_both: assert property (mc_wr |-> !(hp_wdata[3] && hp_wdata[5]))
    else $error("read and write requests set together");
  a_lock_holds: assert property (mc_rd && lock_r |=> hp_rdata[7] && hp_rdata[3] == hrd_r && hp_rdata[5] == hwt_r)
    else $error("locked requests not held");
  a_unlock_view: assert property (mc_rd && !lock_r |=> !hp_rdata[7] && hp_rdata[0] == dir_r)
    else $error("unlocked control view wrong");
  a_fetch_ends: assert property (mc_wr && hp_wdata[3] && !hp_wdata[7] |-> ##[1:40] hp_ready)
    else $error("single fetch never completed");
endmodule

// ### test/test_host_port_memory_access_control.sv
// Self-checking bench joining the host and device ends over the port link
`timescale 1ns/100ps
module test_host_port_memory_access_control;
  typedef struct packed {
    logic [1:0]  k;
    logic [8:0]  a;
    logic [31:0] v;
  } hpm_row_t;
  localparam int NROW = 40;

  logic        i_clk;
  logic        i_srst;
  logic        h_req;
  logic        h_wr;
  logic [5:0]  h_idx;
  logic [31:0] h_wdata;
  logic        o_busy;
  logic [31:0] o_rdata;
  logic        o_rvalid;
  logic [8:0]  c_addr;
  logic [31:0] c_wdata;
  logic        c_wr;
  logic        c_rd;
  logic [31:0] o_cpu_rdata;
  logic [31:0] lk;
  logic [31:0] hr;
  int          n_errors;
  int          total_checks;

  // Kind 0 host write, 1 host read, 2 cpu write, 3 cpu read; v is data or expected value
  hpm_row_t rows [NROW] = '{
    '{2'h0, 9'h002, 32'h00000010},
    '{2'h1, 9'h002, 32'h00000010},
    '{2'h0, 9'h003, 32'hA5A50001},
    '{2'h0, 9'h001, 32'h00000020},
    '{2'h3, 9'h110, 32'hA5A50001},
    '{2'h1, 9'h002, 32'h00000010},
    '{2'h1, 9'h001, 32'h00000000},
    '{2'h2, 9'h114, 32'hCAFE0002},
    '{2'h2, 9'h110, 32'h0BAD0003},
    '{2'h0, 9'h001, 32'h00000008},
    '{2'h1, 9'h003, 32'h0BAD0003},
    '{2'h1, 9'h001, 32'h00000000},
    '{2'h0, 9'h001, 32'h000000A8},
    '{2'h1, 9'h001, 32'h00000088},
    '{2'h1, 9'h003, 32'h0BAD0003},
    '{2'h1, 9'h003, 32'hCAFE0002},
    '{2'h1, 9'h002, 32'h0000001C},
    '{2'h3, 9'h008, 32'h0000001C},
    '{2'h0, 9'h001, 32'h00000000},
    '{2'h0, 9'h002, 32'h00000020},
    '{2'h0, 9'h001, 32'h000000A1},
    '{2'h1, 9'h001, 32'h000000A1},
    '{2'h0, 9'h003, 32'h11110004},
    '{2'h0, 9'h003, 32'h22220005},
    '{2'h0, 9'h001, 32'h00000000},
    '{2'h3, 9'h120, 32'h11110004},
    '{2'h3, 9'h11C, 32'h22220005},
    '{2'h1, 9'h002, 32'h00000018},
    '{2'h2, 9'h000, 32'h000000FF},
    '{2'h3, 9'h000, 32'h00000000},
    '{2'h0, 9'h001, 32'hFFFFFF48},
    '{2'h1, 9'h001, 32'h00000000},
    '{2'h2, 9'h004, 32'h00000004},
    '{2'h2, 9'h100, 32'h11223344},
    '{2'h0, 9'h002, 32'h00000000},
    '{2'h0, 9'h001, 32'h00000008},
    '{2'h1, 9'h003, 32'h44332211},
    '{2'h2, 9'h004, 32'h00000001},
    '{2'h1, 9'h000, 32'h01000000},
    '{2'h2, 9'h004, 32'h00000000}
  };

  hpm_if i_hpm_if ();

  hpm_device i_hpm_device (.link(i_hpm_if), .i_clk(i_clk), .i_srst(i_srst), .i_cpu_addr(c_addr),
    .i_cpu_wdata(c_wdata), .i_cpu_wr(c_wr), .i_cpu_rd(c_rd), .o_cpu_rdata(o_cpu_rdata));

  hpm_host i_hpm_host (.link(i_hpm_if), .i_clk(i_clk), .i_srst(i_srst), .i_req(h_req), .i_wr(h_wr),
    .i_index(h_idx), .i_wdata(h_wdata), .o_busy(o_busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid));

  hpm_props i_hpm_props (.i_clk(i_clk), .i_srst(i_srst), .hp_rs(i_hpm_if.hp_rs), .hp_wr(i_hpm_if.hp_wr),
    .hp_rd(i_hpm_if.hp_rd), .hp_wdata(i_hpm_if.hp_wdata), .hp_rdata(i_hpm_if.hp_rdata),
    .hp_rvalid(i_hpm_if.hp_rvalid), .hp_ready(i_hpm_if.hp_ready));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Waits for two idle cycles so a late read pulse is still caught
  task automatic host_op(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    int m;
    n = 0;
    m = 0;
    lk = 32'hX;
    hr = 32'hX;
    @(posedge i_clk);
    h_req <= 1'b1;
    h_wr <= w;
    h_idx <= idx;
    h_wdata <= d;
    @(posedge i_clk);
    h_req <= 1'b0;
    do begin
      @(posedge i_clk);
      #1;
      if (i_hpm_if.hp_rvalid === 1'b1) lk = i_hpm_if.hp_rdata;
      if (o_rvalid === 1'b1) hr = o_rdata;
      if (o_busy === 1'b0) m++;
      n++;
    end while (n < 60 && m < 2);
    if (n >= 60) begin
      n_errors++;
      $display("mismatch at %0t: host request hung", $time);
      print_verdict();
    end
    if (!w) chk(hr, lk);
  endtask

  task automatic cpu_op(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge i_clk);
    c_wr <= w;
    c_rd <= !w;
    c_addr <= a;
    c_wdata <= d;
    @(posedge i_clk);
    c_wr <= 1'b0;
    c_rd <= 1'b0;
    #1;
  endtask

  // Sixteen locked writes through the internal FIFO, read back by the CPU
  task automatic fifo_run();
    host_op(1'b1, 6'h02, 32'h00000040);
    host_op(1'b1, 6'h01, 32'h000000A0);
    for (int j = 0; j < 16; j++) begin
      host_op(1'b1, 6'h03, 32'h5A000000 + 32'(j));
    end
    host_op(1'b1, 6'h01, 32'h00000000);
    for (int j = 0; j < 16; j++) begin
      cpu_op(1'b0, 9'h140 + 9'(4 * j), 32'h0);
      chk(o_cpu_rdata, 32'h5A000000 + 32'(j));
    end
    cpu_op(1'b0, 9'h008, 32'h0);
    chk(o_cpu_rdata, 32'h00000080);
    cpu_op(1'b0, 9'h00C, 32'h0);
    chk(o_cpu_rdata, 32'h00000000);
  endtask

  initial begin
    {i_srst, h_req, h_wr, c_wr, c_rd} = 5'h10;
    h_idx = 6'h00;
    h_wdata = 32'h0;
    c_addr = 9'h000;
    c_wdata = 32'h0;
    n_errors = 0;
    total_checks = 0;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk({27'h0, o_busy, i_hpm_if.hp_ready, i_hpm_if.hp_rs, i_hpm_if.hp_rvalid, o_rvalid}, 32'h0000000C);
    chk(o_cpu_rdata, 32'h0);
    for (int i = 0; i < NROW; i++) begin
      case (rows[i].k)
        2'h0: host_op(1'b1, rows[i].a[5:0], rows[i].v);
        2'h1: begin
          host_op(1'b0, rows[i].a[5:0], 32'h0);
          chk(lk, rows[i].v);
        end
        2'h2: cpu_op(1'b1, rows[i].a, rows[i].v);
        default: begin
          cpu_op(1'b0, rows[i].a, 32'h0);
          chk(o_cpu_rdata, rows[i].v);
        end
      endcase
    end
    // Order bit set after the index write lands; word swap must still win
    fork
      host_op(1'b0, 6'h03, 32'h0);
      begin
        repeat (3) @(posedge i_clk);
        cpu_op(1'b1, 9'h004, 32'h00000005);
      end
    join
    chk(lk, 32'h44332211);
    cpu_op(1'b1, 9'h004, 32'h00000000);
    // Reset in mid-run after the order bit and address were left nonzero
    host_op(1'b1, 6'h02, 32'h00000044);
    cpu_op(1'b1, 9'h004, 32'h00000005);
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk({28'h0, o_busy, i_hpm_if.hp_ready, i_hpm_if.hp_rs, i_hpm_if.hp_rvalid}, 32'h00000006);
    cpu_op(1'b0, 9'h004, 32'h0);
    chk(o_cpu_rdata, 32'h0);
    cpu_op(1'b0, 9'h008, 32'h0);
    chk(o_cpu_rdata, 32'h0);
    host_op(1'b0, 6'h01, 32'h0);
    chk(lk, 32'h0);
    fifo_run();
    print_verdict();
  end
endmodule
